// [hw/plps_consts.svh]
/*
  Offsets, field positions, reset values and bus codes of the port pin
  configuration block. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef PLPS_CONSTS_SVH
`define PLPS_CONSTS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses, one word per port inside a group)
// ----------------------------------------------------------------------
`define PLPS_ADDR_W 8
`define PLPS_GRP_LATCH 4'h0
`define PLPS_GRP_DIR 4'h1
`define PLPS_GRP_IBUF 4'h2
`define PLPS_GRP_OKIND 4'h3
`define PLPS_GRP_PULL 4'h4
`define PLPS_GRP_MISC 4'h5
`define PLPS_IDX_ANALOG 2'h0
`define PLPS_IDX_REDIR 2'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PLPS_RST_LATCH 8'h00
`define PLPS_RST_DIR 8'hff
`define PLPS_RST_IBUF 8'h00
`define PLPS_RST_OKIND 8'h00
`define PLPS_RST_PULL 8'h00
`define PLPS_RST_ANALOG 8'hff
`define PLPS_RST_REDIR 8'h00

// ----------------------------------------------------------------------
// redirection field positions and codes
// ----------------------------------------------------------------------
`define PLPS_TOUT_LSB 2
`define PLPS_TIO_LSB 0
`define PLPS_TOUT_P30 2'h0
`define PLPS_TOUT_P50 2'h1
`define PLPS_TOUT_P00 2'h2
`define PLPS_TIO_P01 2'h0
`define PLPS_TIO_P31 2'h1

// ----------------------------------------------------------------------
// pin indices (port slot * 8 + bit); slots are ports 0, 1, 3, 5
// ----------------------------------------------------------------------
`define PLPS_PIN_P00 0
`define PLPS_PIN_P01 1
`define PLPS_PIN_P30 16
`define PLPS_PIN_P31 17
`define PLPS_PIN_P50 24

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define PLPS_RESP_OKAY 2'h0
`define PLPS_RESP_SLVERR 2'h2

`endif

// [hw/plps_pkg.sv]
/*
  Types of the port pin configuration block.
  Assumes plps_consts.svh for all numeric values.
*/
package plps_pkg;
  // write channel progress of the register slave
  typedef enum logic [1:0] {
    plps_wr_collect,
    plps_wr_answer
  } plps_wr_state_type;
endpackage : plps_pkg

// [hw/plps_port_pins.sv]
/*
  Pin configuration for ports 0, 1, 3 and 5: output latch, direction,
  CMOS/TTL input buffer, push-pull/open-drain output, pull-up enable,
  analog select on port 0 and interval timer pin redirection.
  Assumes pins arrive asynchronously and peripherals share aclk.
*/
`timescale 1ns/1ns
`include "plps_consts.svh"

// Operation
// - ibuf bit 1 selects TTL input buffer
// - okind bit 1 gives open-drain output
// - after reset all pins are inputs, Hi-Z
// - open-drain high data releases line
// - I2C order; input passes in output mode
// - timer output on P00 only for 10B
// - timer I/O on P01 only for 00B
// - redirectable functions move only by redirection
// - analog select 1 analog, resets ones
// - open-drain disconnects internal pull-up
module plps_port_pins
  import plps_pkg::*;
#(
  parameter int PORTS = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PORTS*8-1:0] pin_in,
  output logic [PORTS*8-1:0] pin_out,
  output logic [PORTS*8-1:0] pin_oe,
  output logic [PORTS*8-1:0] pin_ttl_sel,
  output logic [PORTS*8-1:0] pin_pullup_en,
  output logic [7:0] pin_analog_sel,
  input wire logic serial1_transmit,
  input wire logic interval_timer_output,
  input wire logic interval_timer_io_out,
  input wire logic timer_channel0_output,
  output logic serial1_receive,
  output logic interval_timer_io_in
);

  // the pin map and the register decode are laid out for four ports only
  if (PORTS != 4) begin : g_ports_check
    $error("plps_port_pins serves exactly four ports");
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] latch [PORTS];
  logic [7:0] direction [PORTS];
  logic [7:0] ibuf [PORTS];
  logic [7:0] okind [PORTS];
  logic [7:0] pull [PORTS];
  logic [7:0] analog_digital_select_port0;
  logic [7:0] function_redirect_control;
  logic [PORTS*8-1:0] pin_meta;
  logic [PORTS*8-1:0] pin_sync;
  plps_wr_state_type wr_state;
  logic aw_got;
  logic w_got;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [1:0] timer_out_route;
  logic [1:0] timer_io_route;
  logic [PORTS*8-1:0] next_pin_out;
  logic [PORTS*8-1:0] next_pin_oe;
  logic [PORTS*8-1:0] next_pin_pullup_en;

  assign timer_out_route =
    function_redirect_control[`PLPS_TOUT_LSB +: 2];
  assign timer_io_route = function_redirect_control[`PLPS_TIO_LSB +: 2];

  // ----------------------------------------------------------------------
  // pin synchroniser: first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  // address and data may arrive in either order; the answer follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= plps_wr_collect;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 8'h00;
      wr_byte <= 8'h00;
      wr_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLPS_RESP_OKAY;
    end else begin
      case (wr_state)
        plps_wr_collect: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
          end
          if (aw_got && w_got) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PLPS_RESP_OKAY : `PLPS_RESP_SLVERR;
            wr_state <= plps_wr_answer;
          end
        end
        plps_wr_answer: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state <= plps_wr_collect;
          end
        end
        default: begin
          wr_state <= plps_wr_collect;
        end
      endcase
    end
  end

  assign wr_hit = (wr_addr[7:4] <= `PLPS_GRP_PULL) ||
    (wr_addr[7:4] == `PLPS_GRP_MISC && !wr_addr[3]);

  // ----------------------------------------------------------------------
  // register writes; only byte lane 0 holds data
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < PORTS; p++) begin
        latch[p] <= `PLPS_RST_LATCH;
        direction[p] <= `PLPS_RST_DIR;
        ibuf[p] <= `PLPS_RST_IBUF;
        okind[p] <= `PLPS_RST_OKIND;
        pull[p] <= `PLPS_RST_PULL;
      end
      analog_digital_select_port0 <= `PLPS_RST_ANALOG;
      function_redirect_control <= `PLPS_RST_REDIR;
    end else if (wr_state == plps_wr_collect && aw_got && w_got &&
                 wr_lane0) begin
      case (wr_addr[7:4])
        `PLPS_GRP_LATCH: latch[wr_addr[3:2]] <= wr_byte;
        `PLPS_GRP_DIR: direction[wr_addr[3:2]] <= wr_byte;
        `PLPS_GRP_IBUF: ibuf[wr_addr[3:2]] <= wr_byte;
        `PLPS_GRP_OKIND: okind[wr_addr[3:2]] <= wr_byte;
        `PLPS_GRP_PULL: pull[wr_addr[3:2]] <= wr_byte;
        `PLPS_GRP_MISC: begin
          if (wr_addr[3:2] == `PLPS_IDX_ANALOG) begin
            analog_digital_select_port0 <= wr_byte;
          end else if (wr_addr[3:2] == `PLPS_IDX_REDIR) begin
            // prohibited code 11b is stored but routes nowhere
            function_redirect_control <= {4'h0, wr_byte[3:0]};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  // port data reads the pin in input mode and the latch in output mode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:4])
      `PLPS_GRP_LATCH: begin
        for (int b = 0; b < 8; b++) begin
          rd_word[b] = direction[s_axi_araddr[3:2]][b] ?
            pin_sync[{s_axi_araddr[3:2], 3'(b)}] :
            latch[s_axi_araddr[3:2]][b];
        end
      end
      `PLPS_GRP_DIR: rd_word[7:0] = direction[s_axi_araddr[3:2]];
      `PLPS_GRP_IBUF: rd_word[7:0] = ibuf[s_axi_araddr[3:2]];
      `PLPS_GRP_OKIND: rd_word[7:0] = okind[s_axi_araddr[3:2]];
      `PLPS_GRP_PULL: rd_word[7:0] = pull[s_axi_araddr[3:2]];
      `PLPS_GRP_MISC: begin
        if (s_axi_araddr[3:2] == `PLPS_IDX_ANALOG) begin
          rd_word[7:0] = analog_digital_select_port0;
        end else if (s_axi_araddr[3:2] == `PLPS_IDX_REDIR) begin
          rd_word[7:0] = function_redirect_control;
        end else begin
          rd_hit = 1'b0;
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PLPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `PLPS_RESP_OKAY : `PLPS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // per-pin drive: data source, driver kind, pull-up
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < PORTS * 8; g++) begin : g_pin
    logic alt_or;
    logic data;
    logic analog;
    logic drive;
    // redirectable timer signals join only their selected pin
    always_comb begin
      alt_or = 1'b0;
      if (g == `PLPS_PIN_P00) begin
        alt_or = (timer_out_route == `PLPS_TOUT_P00) &
          interval_timer_output;
      end else if (g == `PLPS_PIN_P30) begin
        alt_or = (timer_out_route == `PLPS_TOUT_P30) &
          interval_timer_output;
      end else if (g == `PLPS_PIN_P50) begin
        alt_or = (timer_out_route == `PLPS_TOUT_P50) &
          interval_timer_output;
      end else if (g == `PLPS_PIN_P01) begin
        alt_or = timer_channel0_output |
          ((timer_io_route == `PLPS_TIO_P01) &
           interval_timer_io_out);
      end else if (g == `PLPS_PIN_P31) begin
        alt_or = (timer_io_route == `PLPS_TIO_P31) &
          interval_timer_io_out;
      end
    end
    // serial transmit gates P00, so it idles high while the timer drives
    assign data = (g == `PLPS_PIN_P00) ?
      ((latch[g/8][g%8] | alt_or) & serial1_transmit) :
      (latch[g/8][g%8] | alt_or);
    assign analog = (g < 8) && analog_digital_select_port0[g%8];
    assign drive = !direction[g/8][g%8] && !analog;
    always_comb begin
      if (okind[g/8][g%8]) begin
        // open-drain: only ever pulls low, a high releases the line
        next_pin_out[g] = 1'b0;
        next_pin_oe[g] = drive && !data;
      end else begin
        next_pin_out[g] = data;
        next_pin_oe[g] = drive;
      end
      next_pin_pullup_en[g] = pull[g/8][g%8] && !okind[g/8][g%8];
    end
  end

  // ----------------------------------------------------------------------
  // registered pad controls and peripheral inputs
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup_en <= '0;
      pin_ttl_sel <= '0;
      pin_analog_sel <= `PLPS_RST_ANALOG;
      serial1_receive <= 1'b0;
      interval_timer_io_in <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_pullup_en <= next_pin_pullup_en;
      for (int p = 0; p < PORTS; p++) begin
        pin_ttl_sel[p*8 +: 8] <= ibuf[p];
      end
      pin_analog_sel <= analog_digital_select_port0;
      // input path stays live in output mode for open-drain i2c
      serial1_receive <= pin_sync[`PLPS_PIN_P01];
      interval_timer_io_in <=
        (timer_io_route == `PLPS_TIO_P01) ? pin_sync[`PLPS_PIN_P01] :
        (timer_io_route == `PLPS_TIO_P31) ? pin_sync[`PLPS_PIN_P31] :
        1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_od_high;
    okind[0][1] && latch[0][1] && !direction[0][1] &&
      !analog_digital_select_port0[1] && !timer_channel0_output &&
      !interval_timer_io_out;
  endsequence

  property p_ttl;
    @(posedge aclk) disable iff (!aresetn)
      pin_ttl_sel[8 +: 8] == $past(ibuf[1]);
  endproperty
  a_ttl: assert property (p_ttl) else $error("ttl select lags");

  property p_od_low;
    @(posedge aclk) disable iff (!aresetn)
      okind[1][0] |=> !pin_out[8];
  endproperty
  a_od_low: assert property (p_od_low) else $error("od drove high");

  property p_od_release;
    @(posedge aclk) disable iff (!aresetn)
      s_od_high |=> !pin_oe[1];
  endproperty
  a_od_release: assert property (p_od_release)
    else $error("od high not released");

  property p_od_zero;
    @(posedge aclk) disable iff (!aresetn)
      okind[1][3] && !latch[1][3] && !direction[1][3] |=> pin_oe[11];
  endproperty
  a_od_zero: assert property (p_od_zero)
    else $error("od zero not driven");

  property p_reset_hiz;
    @(posedge aclk) !aresetn |=> pin_oe == '0;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz)
    else $error("pin driven after reset");

  property p_pull_off;
    @(posedge aclk) disable iff (!aresetn)
      okind[1][2] |=> !pin_pullup_en[10];
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull-up on open-drain");

  property p_tout_route;
    @(posedge aclk) disable iff (!aresetn)
      timer_out_route != `PLPS_TOUT_P00 && !latch[0][0] |=> !pin_out[0];
  endproperty
  a_tout_route: assert property (p_tout_route)
    else $error("timer out leaked to P00");

  property p_rx_live;
    @(posedge aclk) disable iff (!aresetn)
      !direction[0][1] ##1 1'b1 |=> serial1_receive == $past(pin_sync[1]);
  endproperty
  a_rx_live: assert property (p_rx_live)
    else $error("receive blocked in output mode");

  property p_analog_off;
    @(posedge aclk) disable iff (!aresetn)
      analog_digital_select_port0[2] |=> !pin_oe[2];
  endproperty
  a_analog_off: assert property (p_analog_off)
    else $error("analog pin driven");

  property p_tio_route;
    @(posedge aclk) disable iff (!aresetn)
      timer_io_route == `PLPS_TIO_P31 |=>
        interval_timer_io_in == $past(pin_sync[17]);
  endproperty
  a_tio_route: assert property (p_tio_route)
    else $error("timer io from wrong pin");

endmodule : plps_port_pins

// [verification/plps_far_end.sv]
/*
  Far-side model: an external device on another supply, with the board
  pull-up on every pad. Assumes the pad split into out, enable and input.
*/
`timescale 1ns/1ns

module plps_far_end (
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_low,
  output logic [31:0] pin_in
);
  // -------------------------------------------------------------
  // wire resolution
  // -------------------------------------------------------------
  // a released pad floats to the board pull-up, never to a stale value;
  // the far device may sink any line, which wins over a high drive
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i] & ~ext_low[i];
      end else begin
        pin_in[i] = ~ext_low[i];
      end
    end
  end
endmodule : plps_far_end

// [verification/tb.sv]
/*
  Self-checking bench of the port pin configuration block.
  Assumes plps_consts.svh on the include path and the far-end model.
*/
`timescale 1ns/1ns
`include "plps_consts.svh"

module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] pin_in, pin_out, pin_oe, pin_ttl_sel, pin_pullup_en;
  logic [31:0] ext_low = 32'h0;
  logic [31:0] rd;
  logic [7:0] pin_analog_sel;
  logic serial1_transmit = 1'b1, interval_timer_output = 1'b0;
  logic interval_timer_io_out = 1'b0, timer_channel0_output = 1'b0;
  logic serial1_receive, interval_timer_io_in;
  logic [7:0] row_a [10];
  logic [7:0] row_v [10];
  int failures = 0;
  int n_tests = 0;

  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end

  always #20 aclk = ~aclk;

  plps_port_pins #(.PORTS(4)) u_plps_port_pins (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pin_ttl_sel,
    .pin_pullup_en, .pin_analog_sel, .serial1_transmit,
    .interval_timer_output, .interval_timer_io_out,
    .timer_channel0_output, .serial1_receive, .interval_timer_io_in);

  plps_far_end u_plps_far_end (.pin_out, .pin_oe, .ext_low, .pin_in);

  // -------------------------------------------------------------
  // closing report and bus tasks
  // -------------------------------------------------------------
  task stop_test;
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] ad(input logic [3:0] g, input int s);
    return {g, s[1:0], 2'b00};
  endfunction : ad

  // offers address and data together, drops each once taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task rdw(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdw

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    row_a = '{ad(`PLPS_GRP_DIR, 0), ad(`PLPS_GRP_DIR, 1),
      ad(`PLPS_GRP_DIR, 2), ad(`PLPS_GRP_DIR, 3), ad(`PLPS_GRP_IBUF, 0),
      ad(`PLPS_GRP_OKIND, 2), ad(`PLPS_GRP_PULL, 3), 8'h50, 8'h54,
      ad(`PLPS_GRP_LATCH, 1)};
    // input pins read back the pulled-up pad, hence ff on the latch row
    row_v = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff,
      8'h00, 8'hff};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("oe", 32'h0, pin_oe)
    `CHK("asel", 8'hff, pin_analog_sel)
    for (int i = 0; i < 10; i++) begin
      rdw(row_a[i]);
      `CHK("reset", {24'h0, row_v[i]}, rd)
    end
    // one pattern per port, seen on the buffer selects
    for (int s = 0; s < 4; s++) begin
      wr(ad(`PLPS_GRP_IBUF, s), 8'(8'h11 * (s + 1)));
    end
    `CHK("ttl", 32'h44332211, pin_ttl_sel)
    // port 1: latch, open-drain, pull-ups, then output direction
    wr(ad(`PLPS_GRP_LATCH, 1), 8'hf0);
    wr(ad(`PLPS_GRP_OKIND, 1), 8'h3c);
    wr(ad(`PLPS_GRP_PULL, 1), 8'hff);
    `CHK("oe1 in", 8'h00, pin_oe[15:8])
    wr(ad(`PLPS_GRP_DIR, 1), 8'h00);
    `CHK("oe1", 8'hcf, pin_oe[15:8])
    `CHK("out1", 8'hc0, pin_out[15:8])
    `CHK("pull1", 8'hc3, pin_pullup_en[15:8])
    // port 0 receive pin in open-drain output mode, far end talking
    wr(8'h50, 8'hfc);
    wr(ad(`PLPS_GRP_LATCH, 0), 8'h03);
    wr(ad(`PLPS_GRP_OKIND, 0), 8'h03);
    wr(ad(`PLPS_GRP_IBUF, 0), 8'h13);
    `CHK("ttl rx", 1'b1, pin_ttl_sel[1])
    wr(ad(`PLPS_GRP_DIR, 0), 8'hfc);
    `CHK("oe0", 2'b00, pin_oe[1:0])
    ext_low[1] <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK("rx low", 1'b0, serial1_receive)
    ext_low[1] <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("rx high", 1'b1, serial1_receive)
    // timer output route: P00, P30, P50 push-pull outputs at 0
    wr(ad(`PLPS_GRP_OKIND, 0), 8'h00);
    wr(ad(`PLPS_GRP_LATCH, 0), 8'h00);
    wr(ad(`PLPS_GRP_DIR, 0), 8'hfe);
    for (int s = 2; s < 4; s++) begin
      wr(ad(`PLPS_GRP_LATCH, s), 8'h00);
      wr(ad(`PLPS_GRP_DIR, s), 8'hfe);
    end
    interval_timer_output <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(8'h54, 8'(r << `PLPS_TOUT_LSB));
      `CHK("tout", {r == 1, r == 0, r == 2},
        {pin_out[24], pin_out[16], pin_out[0]})
    end
    // timer I/O route: P01 and P31 inputs at opposite levels
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 4; r++) begin
        ext_low[1] <= p[0];
        ext_low[17] <= ~p[0];
        wr(8'h54, 8'(r));
        repeat (4) @(posedge aclk);
        `CHK("tio", (r == 0) ? ~p[0] : (r == 1) ? p[0] : 1'b0,
          interval_timer_io_in)
      end
    end
    // unmapped places and the unused upper nibble
    wr(8'h58, 8'h5a);
    `CHK("wr bad", `PLPS_RESP_SLVERR, resp)
    rdw(8'hfc);
    `CHK("rd bad", `PLPS_RESP_SLVERR, resp)
    `CHK("rd bad data", 32'h0, rd)
    wr(8'h54, 8'hff);
    rdw(8'h54);
    `CHK("redir", 32'h0000000f, rd)
    // mid-run reset with port 1 driving: every pad lets go again
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("oe rst", 32'h0, pin_oe)
    `CHK("asel rst", 8'hff, pin_analog_sel)
    rdw(ad(`PLPS_GRP_DIR, 1));
    `CHK("dir rst", 32'h000000ff, rd)
    stop_test();
  end
endmodule : tb
